// file: src/ssc_top.sv
// Functional notes
// - The enable bit turns the port on and hands the clock, data and select pins to it.
// - With idle-stop set the port halts while the device idles, otherwise it keeps running.
// - The element count shows pending transfers as master and unread transfers as slave.
// - The shift-register-empty flag reads 1 when the shift register is free, else 0.
// - A word completed while the receive buffer is full sets the overflow flag and is lost.
// - The receive-FIFO-empty flag reads 1 with no entries and 0 with at least one.
// - Interrupt mode 111 interrupts when the transmit buffer becomes full.
// - Mode 110 interrupts when a word moves to the shift register leaving the TX FIFO empty.
// - Mode 101 interrupts when the last bit has been shifted out and sending is complete.
// - Mode 100 interrupts when a word moves to the shift register freeing one TX slot.
// - Mode 011 interrupts when the receive buffer is completely full.
// - Mode 010 interrupts when the receive buffer holds three or more words (three quarters of the enhanced FIFO).
// - Mode 001 interrupts while at least one item waits in the receive buffer.
// - Mode 000 interrupts when software reads the last item, emptying the receive buffer.
`timescale 1ns/10ps
module ssc_top (
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   idle_in,
  input  wire logic [ssc_pkg::AW-1:0] reg_addr_in,
  input  wire logic [ssc_pkg::RW-1:0] reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [ssc_pkg::RW-1:0] reg_rdata_out,
  output logic                        irq_out,
  input  wire logic                   sck_in,
  output logic                        sck_out,
  output logic                        sck_oe_n_out,
  input  wire logic                   sdi_in,
  output logic                        sdo_out,
  output logic                        sdo_oe_n_out,
  input  wire logic                   sel_n_in,
  output logic                        pins_owned_out
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic       sck_s;
  logic       sdi_s;
  logic       sel_n_s;

  assign pin_raw = {sck_in, sdi_in, sel_n_in};

  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        // Each pin resets to its idle level, so no false clock edge follows reset
        pin_meta[gi] <= (gi != 2);
        pin_sync[gi] <= (gi != 2);
      end else begin
        pin_meta[gi] <= pin_raw[gi];
        pin_sync[gi] <= pin_meta[gi];
      end
    end
  end

  assign sck_s   = pin_sync[2];
  assign sdi_s   = pin_sync[1];
  assign sel_n_s = pin_sync[0];

  // ==========================================================
  // Register state
  ssc_pkg::ssc_ctrl_t        ctrl, next_ctrl;
  logic [1:0]                mode, next_mode;
  logic [ssc_pkg::IW-1:0]    irq_en, next_irq_en;
  logic [ssc_pkg::IW-1:0]    irq_stat, next_irq_stat;
  logic                      ovf, next_ovf;
  logic [ssc_pkg::RW-1:0]    rdata, next_rdata;
  logic                      irq, next_irq;
  logic                      sck_oe_n, next_sck_oe_n;
  logic                      sdo_oe_n, next_sdo_oe_n;

  // FIFO state
  logic [ssc_pkg::DW-1:0]    tx_mem [ssc_pkg::DEPTH];
  logic [ssc_pkg::DW-1:0]    rx_mem [ssc_pkg::DEPTH];
  logic [1:0]                tx_wp, tx_rp, rx_wp, rx_rp;
  logic [1:0]                next_tx_wp, next_tx_rp;
  logic [1:0]                next_rx_wp, next_rx_rp;
  logic [ssc_pkg::CW-1:0]    tx_cnt, next_tx_cnt;
  logic [ssc_pkg::CW-1:0]    rx_cnt, next_rx_cnt;
  logic                      load, next_load;
  logic [ssc_pkg::DW-1:0]    load_data, next_load_data;

  ssc_pkg::ssc_shift_t       st;
  logic                      wr_ctl, wr_mode, wr_buf, wr_iclr, wr_ien, rd_buf;
  logic [ssc_pkg::CW-1:0]    depth_eff;
  logic                      tx_full, rx_full, halt, can_load;
  logic                      tx_push, tx_pop, rx_push, rx_pop, do_load;
  logic                      ovf_evt, buf_evt;
  logic [ssc_pkg::CW-1:0]    bec;
  logic [ssc_pkg::RW-1:0]    stat_word;
  logic                      sh_busy;

  assign wr_ctl  = reg_wr_in && reg_addr_in == ssc_pkg::OFS_STATCTL;
  assign wr_mode = reg_wr_in && reg_addr_in == ssc_pkg::OFS_MODE;
  assign wr_buf  = reg_wr_in && reg_addr_in == ssc_pkg::OFS_BUF;
  assign wr_iclr = reg_wr_in && reg_addr_in == ssc_pkg::OFS_IRQ_CLR;
  assign wr_ien  = reg_wr_in && reg_addr_in == ssc_pkg::OFS_IRQ_EN;
  assign rd_buf  = reg_rd_in && reg_addr_in == ssc_pkg::OFS_BUF;

  // Outside enhanced mode each direction holds a single word
  assign depth_eff = mode[ssc_pkg::M_ENH] ? 3'(ssc_pkg::DEPTH) : 3'h1;
  assign tx_full   = tx_cnt >= depth_eff;
  assign rx_full   = rx_cnt >= depth_eff;
  assign halt      = ctrl.idle_stop && idle_in;
  assign can_load  = ctrl.enable && !halt && !st.busy && !load;
  assign tx_pop    = can_load && tx_cnt != 3'h0;
  // A slave with nothing queued still shifts, sending zeros
  assign do_load   = tx_pop || (can_load && !mode[ssc_pkg::M_MASTER]);
  assign tx_push   = wr_buf && ctrl.enable && !tx_full;
  assign rx_pop    = rd_buf && rx_cnt != 3'h0;
  assign rx_push   = st.done && !rx_full;
  assign ovf_evt   = st.done && rx_full;

  // pending work as master, unread words as slave
  // A word already popped and on its way into the shifter is still pending
  assign sh_busy = st.busy || load;
  assign bec = mode[ssc_pkg::M_MASTER] ? 3'(tx_cnt + {2'h0, sh_busy}) : rx_cnt;

  always_comb begin
    stat_word                    = ssc_pkg::RST_WORD;
    stat_word[ssc_pkg::B_EN]     = ctrl.enable;
    stat_word[ssc_pkg::B_SIDL]   = ctrl.idle_stop;
    stat_word[ssc_pkg::B_BEC+:3] = bec;
    stat_word[ssc_pkg::B_SREMP]  = !sh_busy;
    stat_word[ssc_pkg::B_ROV]    = ovf;
    stat_word[ssc_pkg::B_RXMPT]  = rx_cnt == 3'h0;
    stat_word[ssc_pkg::B_IMODE+:3] = ctrl.irq_mode;
    stat_word[ssc_pkg::B_TBF]    = tx_full;
    stat_word[ssc_pkg::B_RBF]    = rx_full;
  end

  // ==========================================================
  // Buffer interrupt condition selected by the mode field
  always_comb begin
    case (ctrl.irq_mode)
      ssc_pkg::SIS_TX_FULL:  buf_evt = tx_full;
      ssc_pkg::SIS_TX_EMPTY: buf_evt = tx_pop && tx_cnt == 3'h1;
      ssc_pkg::SIS_TX_DONE:  buf_evt = st.done && tx_cnt == 3'h0 && !load;
      ssc_pkg::SIS_TX_SLOT:  buf_evt = tx_pop;
      ssc_pkg::SIS_RX_FULL:  buf_evt = rx_full;
      ssc_pkg::SIS_RX_3Q:    buf_evt = rx_cnt >= ssc_pkg::RX_3Q;
      ssc_pkg::SIS_RX_AVAIL: buf_evt = rx_cnt != 3'h0;
      ssc_pkg::SIS_RX_LAST:  buf_evt = rx_pop && rx_cnt == 3'h1;
      default:               buf_evt = 1'b0;
    endcase
  end

  // ==========================================================
  // FIFOs and shift loading
  always_comb begin
    next_tx_wp     = tx_wp + 2'(tx_push);
    next_tx_rp     = tx_rp + 2'(tx_pop);
    next_rx_wp     = rx_wp + 2'(rx_push);
    next_rx_rp     = rx_rp + 2'(rx_pop);
    next_tx_cnt    = 3'(tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop});
    next_rx_cnt    = 3'(rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop});
    next_load      = do_load;
    next_load_data = tx_pop ? tx_mem[tx_rp] : 8'h00;
    if (!ctrl.enable) begin
      // Turning the port off flushes both directions
      next_tx_wp  = 2'h0;
      next_tx_rp  = 2'h0;
      next_rx_wp  = 2'h0;
      next_rx_rp  = 2'h0;
      next_tx_cnt = 3'h0;
      next_rx_cnt = 3'h0;
      next_load   = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_wp     <= 2'h0;
      tx_rp     <= 2'h0;
      rx_wp     <= 2'h0;
      rx_rp     <= 2'h0;
      tx_cnt    <= 3'h0;
      rx_cnt    <= 3'h0;
      load      <= 1'b0;
      load_data <= 8'h00;
    end else begin
      tx_wp     <= next_tx_wp;
      tx_rp     <= next_tx_rp;
      rx_wp     <= next_rx_wp;
      rx_rp     <= next_rx_rp;
      tx_cnt    <= next_tx_cnt;
      rx_cnt    <= next_rx_cnt;
      load      <= next_load;
      load_data <= next_load_data;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= reg_wdata_in[ssc_pkg::DW-1:0];
    end
    if (rx_push) begin
      rx_mem[rx_wp] <= st.rx_data;
    end
  end

  ssc_shift u_shift (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .en_in       (ctrl.enable),
    .halt_in     (halt),
    .master_in   (mode[ssc_pkg::M_MASTER]),
    .load_in     (load),
    .tx_data_in  (load_data),
    .sck_in      (sck_s),
    .sdi_in      (sdi_s),
    .sel_n_in    (sel_n_s),
    .st_out      (st),
    .sck_out     (sck_out),
    .sdo_out     (sdo_out)
  );

  // ==========================================================
  // Registers, flags and read data
  always_comb begin
    next_ctrl     = ctrl;
    next_mode     = mode;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_ovf      = ovf;
    next_rdata    = 16'h0000;
    if (wr_ctl) begin
      next_ctrl.enable    = reg_wdata_in[ssc_pkg::B_EN];
      next_ctrl.idle_stop = reg_wdata_in[ssc_pkg::B_SIDL];
      next_ctrl.irq_mode  = ssc_pkg::ssc_imode_t'(reg_wdata_in[ssc_pkg::B_IMODE+:3]);
      if (!reg_wdata_in[ssc_pkg::B_ROV]) begin
        next_ovf = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle
    if (ovf_evt) begin
      next_ovf = 1'b1;
    end
    if (wr_mode) begin
      next_mode = reg_wdata_in[1:0];
    end
    if (wr_ien) begin
      next_irq_en = reg_wdata_in[ssc_pkg::IW-1:0];
    end
    if (wr_iclr) begin
      next_irq_stat = irq_stat & ~reg_wdata_in[ssc_pkg::IW-1:0];
    end
    next_irq_stat = next_irq_stat | {ovf_evt, buf_evt};
    if (reg_rd_in) begin
      case (reg_addr_in)
        ssc_pkg::OFS_STATCTL:  next_rdata = stat_word;
        ssc_pkg::OFS_MODE:     next_rdata = {14'h0000, mode};
        ssc_pkg::OFS_BUF:      next_rdata = rx_pop ? {8'h00, rx_mem[rx_rp]} : 16'h0000;
        ssc_pkg::OFS_IRQ_STAT: next_rdata = {14'h0000, irq_stat};
        ssc_pkg::OFS_IRQ_EN:   next_rdata = {14'h0000, irq_en};
        default:               next_rdata = 16'h0000;
      endcase
    end
    next_irq      = |(irq_stat & irq_en);
    next_sck_oe_n = !(ctrl.enable && mode[ssc_pkg::M_MASTER]);
    next_sdo_oe_n = !(ctrl.enable && (mode[ssc_pkg::M_MASTER] || !sel_n_s));
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl     <= '{enable: 1'b0, idle_stop: 1'b0, irq_mode: ssc_pkg::SIS_RX_LAST};
      mode     <= ssc_pkg::RST_MODE;
      irq_en   <= ssc_pkg::RST_IRQ;
      irq_stat <= ssc_pkg::RST_IRQ;
      ovf      <= 1'b0;
      rdata    <= 16'h0000;
      irq      <= 1'b0;
      sck_oe_n <= 1'b1;
      sdo_oe_n <= 1'b1;
    end else begin
      ctrl     <= next_ctrl;
      mode     <= next_mode;
      irq_en   <= next_irq_en;
      irq_stat <= next_irq_stat;
      ovf      <= next_ovf;
      rdata    <= next_rdata;
      irq      <= next_irq;
      sck_oe_n <= next_sck_oe_n;
      sdo_oe_n <= next_sdo_oe_n;
    end
  end

  assign reg_rdata_out  = rdata;
  assign irq_out        = irq;
  assign sck_oe_n_out   = sck_oe_n;
  assign sdo_oe_n_out   = sdo_oe_n;
  assign pins_owned_out = ctrl.enable;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  pin_owner_a: assert property (wr_ctl |=> pins_owned_out == $past(reg_wdata_in[15]))
    else $error("pin ownership does not follow enable write");
  idle_halt_a: assert property (halt |-> !tx_pop ##1 !load)
    else $error("port loaded data while halted in idle");
  elem_count_a: assert property (reg_rd_in && reg_addr_in == ssc_pkg::OFS_STATCTL
      && !mode[ssc_pkg::M_MASTER] |=> reg_rdata_out[10:8] == $past(rx_cnt))
    else $error("slave element count wrong");
  sr_empty_a: assert property (reg_rd_in && reg_addr_in == ssc_pkg::OFS_STATCTL
      |=> reg_rdata_out[7] == !$past(st.busy || load))
    else $error("shift empty flag wrong");
  ovf_set_a: assert property (st.done && rx_full |=> ovf && $stable(rx_cnt))
    else $error("overflow not flagged or data kept");
  rx_empty_a: assert property (reg_rd_in && reg_addr_in == ssc_pkg::OFS_STATCTL
      |=> reg_rdata_out[5] == ($past(rx_cnt) == 3'h0))
    else $error("receive empty flag wrong");
  tx_full_irq_a: assert property (ctrl.irq_mode == ssc_pkg::SIS_TX_FULL && tx_full
      |=> irq_stat[ssc_pkg::I_BUF])
    else $error("transmit full did not interrupt");
  rx_avail_a: assert property (ctrl.irq_mode == ssc_pkg::SIS_RX_AVAIL && rx_cnt != 3'h0
      |=> irq_stat[ssc_pkg::I_BUF] ##1 (irq_out || !$past(irq_en[ssc_pkg::I_BUF])))
    else $error("receive data did not raise interrupt");
  tx_drop_a: assert property (wr_buf && tx_full && !tx_pop |=> $stable(tx_cnt))
    else $error("write into full transmit buffer stored");
  reserved_a: assert property (reg_rd_in && reg_addr_in == ssc_pkg::OFS_STATCTL
      |=> reg_rdata_out[14] == 1'b0 && reg_rdata_out[12:11] == 2'h0)
    else $error("reserved bits not zero");

endmodule // ssc_top

// file: src/ssc_pkg.sv
package ssc_pkg;

  // ==========================================================
  // Widths and depths
  localparam int DW    = 8;
  localparam int RW    = 16;
  localparam int AW    = 3;
  localparam int DEPTH = 4;
  localparam int CW    = 3;

  // ==========================================================
  // Register offsets (word index on the register port)
  localparam logic [AW-1:0] OFS_STATCTL  = 3'h0;
  localparam logic [AW-1:0] OFS_MODE     = 3'h1;
  localparam logic [AW-1:0] OFS_BUF      = 3'h2;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 3'h3;
  localparam logic [AW-1:0] OFS_IRQ_CLR  = 3'h4;
  localparam logic [AW-1:0] OFS_IRQ_EN   = 3'h5;

  // ==========================================================
  // Status and control field positions
  localparam int B_EN    = 15;
  localparam int B_SIDL  = 13;
  localparam int B_BEC   = 8;
  localparam int B_SREMP = 7;
  localparam int B_ROV   = 6;
  localparam int B_RXMPT = 5;
  localparam int B_IMODE = 2;
  localparam int B_TBF   = 1;
  localparam int B_RBF   = 0;

  // Mode register and interrupt register fields
  localparam int M_MASTER = 0;
  localparam int M_ENH    = 1;
  localparam int I_BUF    = 0;
  localparam int I_OVF    = 1;
  localparam int IW       = 2;

  // Reset values
  localparam logic [RW-1:0] RST_WORD = 16'h0000;
  localparam logic [1:0]    RST_MODE = 2'h0;
  localparam logic [IW-1:0] RST_IRQ  = 2'h0;

  // Three quarters of the enhanced receive FIFO
  localparam logic [CW-1:0] RX_3Q = 3'h3;

  // ==========================================================
  // Timing: serial clock generated in master mode
  localparam int CORE_NS      = 40;
  localparam int SCK_HALF_NS  = 160;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CORE_NS - 1) / CORE_NS;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SIS_RX_LAST  = 3'b000,
    SIS_RX_AVAIL = 3'b001,
    SIS_RX_3Q    = 3'b010,
    SIS_RX_FULL  = 3'b011,
    SIS_TX_SLOT  = 3'b100,
    SIS_TX_DONE  = 3'b101,
    SIS_TX_EMPTY = 3'b110,
    SIS_TX_FULL  = 3'b111
  } ssc_imode_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_RUN  = 2'b01
  } ssc_sh_state_t;

  typedef struct packed {
    logic       enable;
    logic       idle_stop;
    ssc_imode_t irq_mode;
  } ssc_ctrl_t;

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [DW-1:0] rx_data;
  } ssc_shift_t;

endpackage

// file: src/ssc_shift.sv
`timescale 1ns/10ps
module ssc_shift (
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  en_in,
  input  wire logic                  halt_in,
  input  wire logic                  master_in,
  input  wire logic                  load_in,
  input  wire logic [ssc_pkg::DW-1:0] tx_data_in,
  input  wire logic                  sck_in,
  input  wire logic                  sdi_in,
  input  wire logic                  sel_n_in,
  output ssc_pkg::ssc_shift_t        st_out,
  output logic                       sck_out,
  output logic                       sdo_out
);

  ssc_pkg::ssc_sh_state_t state, next_state;
  logic [ssc_pkg::DW-1:0] shreg, next_shreg;
  logic [ssc_pkg::DW-1:0] rx, next_rx;
  logic [2:0]             bits, next_bits;
  logic [2:0]             div, next_div;
  logic                   sck, next_sck;
  logic                   sck_d, next_sck_d;
  logic                   sdo, next_sdo;
  logic                   done, next_done;
  logic                   rise;
  logic                   fall;

  // ==========================================================
  // Shift engine, clock idle low, sample on rise, change on fall
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_rx    = rx;
    next_bits  = bits;
    next_div   = div;
    next_sck   = sck;
    next_sck_d = sck_in;
    next_sdo   = sdo;
    next_done  = 1'b0;
    rise       = 1'b0;
    fall       = 1'b0;
    if (master_in) begin
      if (state == ssc_pkg::SH_RUN && !halt_in) begin
        if (div == 3'(ssc_pkg::SCK_HALF_CYC - 1)) begin
          next_div = 3'h0;
          next_sck = !sck;
          rise     = !sck;
          fall     = sck;
        end else begin
          next_div = div + 3'h1;
        end
      end
    end else if (!sel_n_in && !halt_in) begin
      // Slave edges come from the synchronised pin, so the link
      // clock must stay well below the core clock
      rise = sck_in && !sck_d;
      fall = !sck_in && sck_d;
    end
    case (state)
      ssc_pkg::SH_IDLE: begin
        next_sck = 1'b0;
        next_div = 3'h0;
        if (load_in) begin
          next_state = ssc_pkg::SH_RUN;
          next_shreg = tx_data_in;
          next_sdo   = tx_data_in[ssc_pkg::DW-1];
          next_bits  = 3'h0;
        end
      end
      ssc_pkg::SH_RUN: begin
        if (rise) begin
          next_shreg = {shreg[ssc_pkg::DW-2:0], sdi_in};
        end
        if (fall) begin
          next_bits = bits + 3'h1;
          next_sdo  = shreg[ssc_pkg::DW-1];
          if (bits == 3'h7) begin
            next_state = ssc_pkg::SH_IDLE;
            next_done  = 1'b1;
            next_rx    = shreg;
          end
        end
      end
      default: begin
        next_state = ssc_pkg::SH_IDLE;
      end
    endcase
    if (!en_in) begin
      next_state = ssc_pkg::SH_IDLE;
      next_sck   = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= ssc_pkg::SH_IDLE;
      shreg <= 8'h00;
      rx    <= 8'h00;
      bits  <= 3'h0;
      div   <= 3'h0;
      sck   <= 1'b0;
      sck_d <= 1'b0;
      sdo   <= 1'b0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      rx    <= next_rx;
      bits  <= next_bits;
      div   <= next_div;
      sck   <= next_sck;
      sck_d <= next_sck_d;
      sdo   <= next_sdo;
      done  <= next_done;
    end
  end

  assign st_out  = '{busy: (state != ssc_pkg::SH_IDLE), done: done, rx_data: rx};
  assign sck_out = sck;
  assign sdo_out = sdo;

endmodule // ssc_shift

// file: tb/ssc_far_dev.sv
`timescale 1ns/10ps
module ssc_far_dev #(
  parameter logic [7:0] FIRST = 8'h5A
) (
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic sck_in,
  input  wire logic mosi_in,
  output logic      miso_out
);
  // ==========================================================
  // Mode 0 slave: samples on rise, shifts on fall, MSB first
  logic [7:0] sh;
  logic [7:0] rx;
  logic [3:0] cnt;
  logic       sck_q;

  assign miso_out = sh[7];

  always_ff @(posedge core_clk_in) begin
    sck_q <= sck_in;
    if (sys_rst_in) begin
      sh  <= FIRST;
      rx  <= 8'h00;
      cnt <= 4'h0;
    end else if (sck_in && !sck_q) begin
      rx  <= {rx[6:0], mosi_in};
      cnt <= cnt + 4'h1;
    end else if (!sck_in && sck_q) begin
      // Echo the byte just heard; spent bits never linger on the line
      if (cnt == 4'h8) begin
        sh  <= rx;
        cnt <= 4'h0;
      end else begin
        sh <= {sh[6:0], ~sh[0]};
      end
    end
  end
endmodule // ssc_far_dev

// file: tb/tb_ssc_top.sv
`timescale 1ns/10ps
module tb_ssc_top;
  localparam logic [7:0] FIRST = 8'h5A;
  localparam logic       T     = 1'b1;
  localparam logic       F     = 1'b0;
  localparam logic [2:0] LVL [4] = '{3'h7, 3'h3, 3'h2, 3'h1};

  logic                   core_clk_in, sys_rst_in, idle_in, reg_wr_in, reg_rd_in;
  logic [ssc_pkg::AW-1:0] reg_addr_in;
  logic [ssc_pkg::RW-1:0] reg_wdata_in, reg_rdata_out, v;
  logic                   irq_out, sck_out, sck_oe_n_out, sdo_out, sdo_oe_n_out;
  logic                   pins_owned_out, sck_pin, sdo_pin, miso, lnk_sck, sel_n;
  logic [7:0]             b [5];
  logic [7:0]             prev;
  int                     error_cnt, total_checks, seed, k;

  always #20 core_clk_in = ~core_clk_in;

  // Released clock wire carries the bench's link clock (idle low), data out pulled high
  assign sck_pin = sck_oe_n_out ? lnk_sck : sck_out;
  assign sdo_pin = sdo_oe_n_out ? 1'b1 : sdo_out;

  ssc_top ssc_top_i (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .idle_in(idle_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
    .sck_in(sck_pin), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out), .sdi_in(miso),
    .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out), .sel_n_in(sel_n),
    .pins_owned_out(pins_owned_out));

  ssc_far_dev #(.FIRST(FIRST)) ssc_far_dev_i (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck_pin),
    .mosi_in(sdo_pin), .miso_out(miso));

  // ==========================================================
  // Bus tasks and expectations
  function automatic logic [15:0] st(logic en, logic sidl, logic [2:0] bec, logic srm,
                                     logic rov, logic rxm, logic [2:0] sis, logic tbf, logic rbf);
    return {en, 1'b0, sidl, 2'b00, bec, srm, rov, rxm, sis, tbf, rbf};
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_out;
    @(posedge core_clk_in);
    #1;
  endtask

  // Polls until the FIFO and shifter are both empty
  task automatic wait_idle();
    for (int n = 0; n < 300; n++) begin
      rd(ssc_pkg::OFS_STATCTL, v);
      if (v[7] === 1'b1 && v[10:8] === 3'h0)
        return;
    end
    error_cnt++;
    complete_run();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    core_clk_in  = 1'b0;
    sys_rst_in   = 1'b1;
    idle_in      = 1'b0;
    lnk_sck      = 1'b0;
    sel_n        = 1'b1;
    reg_addr_in  = '0;
    reg_wdata_in = '0;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    error_cnt    = 0;
    total_checks = 0;
    seed         = 32'h92B9C1C3;
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(F, F, 3'h0, T, F, T, 3'h0, F, F));
    chk({15'h0000, pins_owned_out}, 16'h0000);
    wr(ssc_pkg::OFS_STATCTL, 16'hFFFF);
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(T, T, 3'h0, F, F, T, 3'h7, F, F));
    chk({15'h0000, pins_owned_out}, 16'h0001);
    wr(ssc_pkg::OFS_MODE, 16'h0003);
    wr(ssc_pkg::OFS_IRQ_EN, 16'h0001);
    wr(ssc_pkg::OFS_STATCTL, 16'h801C);
    wr(ssc_pkg::OFS_IRQ_CLR, 16'h0003);
    for (k = 0; k < 5; k++) begin
      b[k] = 8'($random(seed));
      wr(ssc_pkg::OFS_BUF, {8'h00, b[k]});
    end
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(T, F, 3'h5, F, F, T, 3'h7, T, F));
    chk({15'h0000, irq_out}, 16'h0001);
    chk({15'h0000, sck_oe_n_out}, 16'h0000);
    wait_idle();
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(T, F, 3'h0, T, T, F, 3'h7, F, T));
    rd(ssc_pkg::OFS_IRQ_STAT, v);
    chk(v, 16'h0003);
    for (k = 0; k < 4; k++) begin
      wr(ssc_pkg::OFS_STATCTL, {11'h400, LVL[k], 2'h0});
      wr(ssc_pkg::OFS_IRQ_CLR, 16'h0003);
      rd(ssc_pkg::OFS_IRQ_STAT, v);
      chk(v, {15'h0000, k != 0});
    end
    chk({15'h0000, irq_out}, 16'h0001);
    wr(ssc_pkg::OFS_IRQ_EN, 16'h0000);
    chk({15'h0000, irq_out}, 16'h0000);
    wr(ssc_pkg::OFS_IRQ_EN, 16'h0001);
    wr(ssc_pkg::OFS_STATCTL, 16'h8000);
    for (k = 0; k < 4; k++) begin
      wr(ssc_pkg::OFS_IRQ_CLR, 16'h0003);
      rd(ssc_pkg::OFS_BUF, v);
      chk(v, {8'h00, k == 0 ? FIRST : (k == 1 ? 8'h00 : b[k-2])});
      rd(ssc_pkg::OFS_IRQ_STAT, v);
      chk(v, {15'h0000, k == 3});
    end
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(T, F, 3'h0, T, F, T, 3'h0, F, F));
    rd(ssc_pkg::OFS_BUF, v);
    chk(v, 16'h0000);
    wr(3'h7, 16'hFFFF);
    rd(3'h7, v);
    chk(v, 16'h0000);
    prev = b[3];
    for (k = 4; k < 7; k++) begin
      wr(ssc_pkg::OFS_STATCTL, {11'h400, 3'(k), 2'h0});
      wr(ssc_pkg::OFS_IRQ_CLR, 16'h0003);
      b[0] = 8'($random(seed));
      wr(ssc_pkg::OFS_BUF, {8'h00, b[0]});
      wait_idle();
      rd(ssc_pkg::OFS_IRQ_STAT, v);
      chk(v, 16'h0001);
      rd(ssc_pkg::OFS_BUF, v);
      chk(v, {8'h00, prev});
      prev = b[0];
    end
    wr(ssc_pkg::OFS_STATCTL, 16'hA000);
    idle_in <= 1'b1;
    b[0] = 8'($random(seed));
    wr(ssc_pkg::OFS_BUF, {8'h00, b[0]});
    repeat (40) rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(T, T, 3'h1, T, F, T, 3'h0, F, F));
    wr(ssc_pkg::OFS_STATCTL, 16'h8000);
    wait_idle();
    rd(ssc_pkg::OFS_BUF, v);
    chk(v, {8'h00, prev});
    idle_in <= 1'b0;
    wr(ssc_pkg::OFS_STATCTL, 16'h0000);
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(F, F, 3'h0, T, F, T, 3'h0, F, F));
    chk({14'h0000, pins_owned_out, sck_oe_n_out}, 16'h0001);
    // Slave frame: the bench clocks the link, the far device echoes its last byte
    wr(ssc_pkg::OFS_MODE, 16'h0002);
    wr(ssc_pkg::OFS_STATCTL, 16'h8000);
    sel_n <= 1'b0;
    repeat (16) begin
      repeat (4) @(posedge core_clk_in);
      lnk_sck <= ~lnk_sck;
    end
    repeat (8) @(posedge core_clk_in);
    rd(ssc_pkg::OFS_STATCTL, v);
    chk(v, st(T, F, 3'h1, F, F, F, 3'h0, F, F));
    chk({14'h0000, sck_oe_n_out, sdo_oe_n_out}, 16'h0002);
    rd(ssc_pkg::OFS_BUF, v);
    chk(v, {8'h00, b[0]});
    complete_run();
  end
endmodule // tb_ssc_top
